/* verilog/lip_map.vh */
`ifndef LIP_MAP_VH
`define LIP_MAP_VH

// ----------------------------------------------------------------
// register address codes
// ----------------------------------------------------------------
`define LIP_ADDR_MASTER 8'h0E
`define LIP_ADDR_PAIR10 8'h10
`define LIP_ADDR_PAIR32 8'h11
`define LIP_ADDR_PAIR54 8'h12
`define LIP_ADDR_PAIR76 8'h13

// ----------------------------------------------------------------
// register indices and storage size
// ----------------------------------------------------------------
`define LIP_IDX_MASTER 3'h0
`define LIP_IDX_PAIR10 3'h1
`define LIP_IDX_PAIR32 3'h2
`define LIP_IDX_PAIR54 3'h3
`define LIP_IDX_PAIR76 3'h4
`define LIP_NUM_REGS 5
`define LIP_NUM_PORTS 8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LIP_HI_NIB 7:4
`define LIP_LO_NIB 3:0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define LIP_RST_INTENS 8'h00
`define LIP_RST_RDATA 8'h00
`define LIP_UNMAPPED_RDATA 8'h00
`define LIP_CODE_STATIC 4'hF
`define LIP_CODE_ZERO 4'h0
`define LIP_FINE_LAST 4'hE
`define LIP_SLOT_LAST 4'hF
`define LIP_RW_WRITE 1'b0
`define LIP_RW_READ 1'b1

`endif

/* verilog/lip_pwm_timebase.v */
`timescale 1ns/1ns
`default_nettype none
`include "lip_map.vh"

// shared pwm timebase: 16 slots of 15 fine steps each
module lip_pwm_timebase (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [3:0] master_i,
  output reg [3:0] fine_o,
  output reg [3:0] slot_o,
  output reg run_o,
  output reg frame_end_o
);

  // ----------------------------------------------------------------
  // oscillator enable
  // ----------------------------------------------------------------
  wire run_nxt;
  assign run_nxt = (master_i != `LIP_CODE_ZERO);

  // ----------------------------------------------------------------
  // counters, held at zero while stopped
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fine_o <= 4'h0;
      slot_o <= 4'h0;
      run_o <= 1'b0;
      frame_end_o <= 1'b0;
    end else begin
      run_o <= run_nxt;
      frame_end_o <= 1'b0;
      if (!run_nxt) begin
        fine_o <= 4'h0;
        slot_o <= 4'h0;
      end else if (fine_o == `LIP_FINE_LAST) begin
        fine_o <= 4'h0;
        slot_o <= slot_o + 4'h1;
        if (slot_o == `LIP_SLOT_LAST) begin
          frame_end_o <= 1'b1;
        end
      end else begin
        fine_o <= fine_o + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/lip_pwm_cell.v */
`timescale 1ns/1ns
`default_nettype none
`include "lip_map.vh"

// one output: intensity in sixteenths, scaled by master in fifteenths
module lip_pwm_cell (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [3:0] code_i,
  input wire [3:0] master_i,
  input wire [3:0] fine_i,
  input wire [3:0] slot_i,
  input wire run_i,
  output reg on_o
);

  // ----------------------------------------------------------------
  // duty decision
  // ----------------------------------------------------------------
  reg on_nxt;
  always @* begin
    if (code_i == `LIP_CODE_STATIC) begin
      on_nxt = 1'b1;
    end else if (!run_i) begin
      on_nxt = 1'b0;
    end else begin
      // code+1 slots of 16, master of 15 fine steps per slot
      on_nxt = (slot_i <= code_i) && (fine_i < master_i);
    end
  end

  // ----------------------------------------------------------------
  // registered drive
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      on_o <= 1'b0;
    end else begin
      on_o <= on_nxt;
    end
  end

endmodule
`default_nettype wire

/* verilog/lip_intensity_regs.v */
`timescale 1ns/1ns
`default_nettype none
`include "lip_map.vh"

module lip_intensity_regs (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire host_req_i,
  input wire host_rw_i,
  input wire [7:0] host_addr_i,
  input wire [7:0] host_wdata_i,
  output reg [7:0] host_rdata_o,
  output reg host_rvalid_o,
  output reg host_ack_o,
  output reg host_miss_o,
  output reg osc_run_o,
  output reg [7:0] port_out_o,
  output reg [7:0] port_oe_o,
  output reg extra_output_o,
  output reg extra_output_oe_o
);

  // ----------------------------------------------------------------
  // storage and shadows
  // ----------------------------------------------------------------
  // host-visible intensity registers, indexed by LIP_IDX_*
  reg [7:0] intens_r [0:`LIP_NUM_REGS-1];
  // per-output codes actually applied to the pwm
  reg [3:0] port_code_r [0:`LIP_NUM_PORTS-1];
  reg [3:0] extra_code_r;

  // address decode results
  reg [2:0] idx_nxt;
  reg hit_nxt;

  // read-back value
  reg [7:0] rdata_nxt;

  // timebase outputs
  wire [3:0] fine_w;
  wire [3:0] slot_w;
  wire run_w;
  wire frame_end_w;

  // master field is applied at once: it also gates the oscillator
  wire [3:0] master_w;

  // pwm cell outputs, ports 0..7 then extra output at 8
  wire [`LIP_NUM_PORTS:0] on_w;

  // strobes
  wire wr_stb;
  wire rd_stb;

  // codes may be taken over by the pwm this cycle
  wire apply_w;

  integer k;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // maps address code to storage index, flags unmapped codes
  always @* begin
    idx_nxt = `LIP_IDX_MASTER;
    hit_nxt = 1'b1;
    if (host_addr_i == `LIP_ADDR_MASTER) begin
      idx_nxt = `LIP_IDX_MASTER;
    end else if (host_addr_i == `LIP_ADDR_PAIR10) begin
      idx_nxt = `LIP_IDX_PAIR10;
    end else if (host_addr_i == `LIP_ADDR_PAIR32) begin
      idx_nxt = `LIP_IDX_PAIR32;
    end else if (host_addr_i == `LIP_ADDR_PAIR54) begin
      idx_nxt = `LIP_IDX_PAIR54;
    end else if (host_addr_i == `LIP_ADDR_PAIR76) begin
      idx_nxt = `LIP_IDX_PAIR76;
    end else begin
      hit_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // access strobes
  // ----------------------------------------------------------------
  // unmapped codes do not store, but reads of them still answer with a fixed value
  assign wr_stb = host_req_i && hit_nxt && (host_rw_i == `LIP_RW_WRITE);
  assign rd_stb = host_req_i && (host_rw_i == `LIP_RW_READ);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // each register stores all eight bits of a write, nibbles untouched
  genvar gi;
  generate
    for (gi = 0; gi < `LIP_NUM_REGS; gi = gi + 1) begin : g_reg
      always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          intens_r[gi] <= `LIP_RST_INTENS;
        end else if (wr_stb && (idx_nxt == gi[2:0])) begin
          intens_r[gi] <= host_wdata_i;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read-back mux
  // ----------------------------------------------------------------
  // returns the stored byte, unmapped codes read a fixed value
  always @* begin
    if (hit_nxt) begin
      rdata_nxt = intens_r[idx_nxt];
    end else begin
      rdata_nxt = `LIP_UNMAPPED_RDATA;
    end
  end

  // ----------------------------------------------------------------
  // host answer
  // ----------------------------------------------------------------
  // ack one cycle after every request, data held until next read
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      host_rdata_o <= `LIP_RST_RDATA;
      host_rvalid_o <= 1'b0;
      host_ack_o <= 1'b0;
      host_miss_o <= 1'b0;
    end else begin
      host_ack_o <= host_req_i;
      host_rvalid_o <= rd_stb;
      host_miss_o <= host_req_i && !hit_nxt;
      if (rd_stb) begin
        host_rdata_o <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // master field
  // ----------------------------------------------------------------
  // upper nibble of the master register
  assign master_w = intens_r[`LIP_IDX_MASTER][`LIP_HI_NIB];

  // ----------------------------------------------------------------
  // shared timebase
  // ----------------------------------------------------------------
  lip_pwm_timebase u_timebase (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .master_i(master_w),
    .fine_o(fine_w),
    .slot_o(slot_w),
    .run_o(run_w),
    .frame_end_o(frame_end_w)
  );

  // ----------------------------------------------------------------
  // code hand-over to the pwm
  // ----------------------------------------------------------------
  // new codes wait for the end of a frame so no pulse is cut short;
  // while stopped there is no frame, so they pass straight through
  assign apply_w = frame_end_w || !run_w;

  // lower nibble to even port, upper to odd port
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (k = 0; k < `LIP_NUM_PORTS; k = k + 1) begin
        port_code_r[k] <= `LIP_CODE_ZERO;
      end
      extra_code_r <= `LIP_CODE_ZERO;
    end else if (apply_w) begin
      for (k = 0; k < `LIP_NUM_PORTS; k = k + 2) begin
        port_code_r[k] <= intens_r[(k / 2) + 1][`LIP_LO_NIB];
        port_code_r[k + 1] <= intens_r[(k / 2) + 1][`LIP_HI_NIB];
      end
      extra_code_r <= intens_r[`LIP_IDX_MASTER][`LIP_LO_NIB];
    end
  end

  // ----------------------------------------------------------------
  // per-output modulators
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp <= `LIP_NUM_PORTS; gp = gp + 1) begin : g_cell
      wire [3:0] code_w;
      if (gp == `LIP_NUM_PORTS) begin : g_extra
        assign code_w = extra_code_r;
      end else begin : g_port
        assign code_w = port_code_r[gp];
      end
      lip_pwm_cell u_cell (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .code_i(code_w),
        .master_i(master_w),
        .fine_i(fine_w),
        .slot_i(slot_w),
        .run_i(run_w),
        .on_o(on_w[gp])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // open-drain pin drive
  // ----------------------------------------------------------------
  // led on means the pin sinks current: level low, enable high
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      port_out_o <= 8'h00;
      port_oe_o <= 8'h00;
      extra_output_o <= 1'b0;
      extra_output_oe_o <= 1'b0;
      osc_run_o <= 1'b0;
    end else begin
      port_out_o <= 8'h00;
      port_oe_o <= on_w[`LIP_NUM_PORTS-1:0];
      extra_output_o <= 1'b0;
      extra_output_oe_o <= on_w[`LIP_NUM_PORTS];
      osc_run_o <= run_w;
    end
  end

endmodule
`default_nettype wire

/* test/lip_intensity_regs_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module lip_intensity_regs_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic host_req_i,
  input wire logic host_rw_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic host_rvalid_o,
  input wire logic host_ack_o,
  input wire logic host_miss_o,
  input wire logic osc_run_o,
  input wire logic [7:0] port_out_o,
  input wire logic [7:0] port_oe_o,
  input wire logic extra_output_o,
  input wire logic extra_output_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // shadow registers and quiet-cycle counter
  // ----------------------------------------------------------------
  logic [7:0] mst_r, p10_r, quiet_r;
  logic hit, wr;
  assign hit = host_addr_i inside {8'h0e, [8'h10:8'h13]};
  assign wr = host_req_i && !host_rw_i;
  // track writes, count cycles with no request (saturates)
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mst_r <= 8'h00;
      p10_r <= 8'h00;
      quiet_r <= 8'h00;
    end else begin
      quiet_r <= host_req_i ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hff};
      if (wr && host_addr_i == 8'h0e) mst_r <= host_wdata_i;
      if (wr && host_addr_i == 8'h10) p10_r <= host_wdata_i;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  req_gets_ack_a: assert property (host_req_i |=> host_ack_o && host_miss_o != $past(hit))
    else $error("request not answered correctly");
  idle_quiet_a: assert property (!host_req_i |=> !host_ack_o && !host_rvalid_o)
    else $error("answer without request");
  read_valid_a: assert property (host_req_i && host_rw_i |=> host_rvalid_o)
    else $error("read without valid data");
  rdata_hold_a: assert property (!host_rvalid_o |-> $stable(host_rdata_o))
    else $error("read data moved without a read");
  pair_back_a: assert property (host_req_i && host_rw_i && host_addr_i == 8'h10 |=>
    host_rdata_o == $past(p10_r)) else $error("port pair read-back differs");
  osc_state_a: assert property (quiet_r >= 8'h03 |-> osc_run_o == (mst_r[7:4] != 4'h0))
    else $error("oscillator state wrong");
  static_out_a: assert property (mst_r[7:4] == 4'h0 && quiet_r >= 8'h04 |->
    $stable(port_oe_o) && $stable(extra_output_oe_o)) else $error("pwm while stopped");
  pins_low_a: assert property (port_out_o == 8'h00 && !extra_output_o)
    else $error("pin level not low");
  full_on_a: assert property (quiet_r == 8'hff |-> (p10_r[3:0] != 4'hf || port_oe_o[0])
    && (mst_r[3:0] != 4'hf || extra_output_oe_o)) else $error("static code not fully on");
endmodule
`default_nettype wire

/* test/lip_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lip_host_model (
  input wire logic core_clk_i,
  output logic host_req_o,
  output logic host_rw_o,
  output logic [7:0] host_addr_o,
  output logic [7:0] host_wdata_o
);
  initial begin
    host_req_o = 1'b0;
    host_rw_o = 1'b1;
    host_addr_o = 8'h00;
    host_wdata_o = 8'h00;
  end
  // one access per edge: selector 0 writes, 1 reads
  task automatic access(input logic rw, input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_i);
    host_req_o <= 1'b1;
    host_rw_o <= rw;
    host_addr_o <= addr;
    host_wdata_o <= data;
  endtask
  // released address and data lines show the inverse of their last value
  task automatic idle_bus();
    @(posedge core_clk_i);
    host_req_o <= 1'b0;
    host_addr_o <= ~host_addr_o;
    host_wdata_o <= ~host_wdata_o;
  endtask
endmodule
`default_nettype wire

/* test/led_intensity_pwm_registers_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module led_intensity_pwm_registers_test;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req, rw, rvalid, ack, miss, osc, xo, xo_oe;
  logic [7:0] addr, wdata, rdata, port_out, port_oe, e;
  logic [7:0] regs[5];
  logic [7:0] amap[5] = '{8'h0e, 8'h10, 8'h11, 8'h12, 8'h13};
  logic [7:0] exp_q[$];
  logic [3:0] mtab[6] = '{4'h0, 4'hf, 4'h1, 4'h7, 4'h0, 4'hf};
  logic [3:0] ctab[6] = '{4'hf, 4'he, 4'h0, 4'hf, 4'h3, 4'hf};
  logic [3:0] c;
  int cnt[9];
  int mismatches = 0;
  int check_count = 0;
  int x;
  always #5 core_clk_i = ~core_clk_i;
  lip_host_model host (.core_clk_i(core_clk_i), .host_req_o(req), .host_rw_o(rw),
    .host_addr_o(addr), .host_wdata_o(wdata));
  lip_intensity_regs DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .host_req_i(req),
    .host_rw_i(rw), .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
    .host_rvalid_o(rvalid), .host_ack_o(ack), .host_miss_o(miss), .osc_run_o(osc),
    .port_out_o(port_out), .port_oe_o(port_oe), .extra_output_o(xo),
    .extra_output_oe_o(xo_oe));
  // read-back watcher: oldest note against each answer
  always @(posedge core_clk_i) begin
    if (rvalid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("rdata", e, rdata)
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'ha538_14a6));
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // reset values, then back-to-back write and read of each register
    for (int i = 0; i < 5; i++) begin
      exp_q.push_back(8'h00);
      host.access(1'b1, amap[i], 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      regs[i] = $urandom;
      host.access(1'b0, amap[i], regs[i]);
      exp_q.push_back(regs[i]);
      host.access(1'b1, amap[i], 8'h00);
    end
    // unmapped place: write ignored, reads as zero
    host.access(1'b0, 8'h0f, 8'h5a);
    exp_q.push_back(8'h00);
    host.access(1'b1, 8'h0f, 8'h00);
    // on-cycles over one 240-cycle frame for every output
    for (int t = 0; t < 6; t++) begin
      regs[0] = {mtab[t], ctab[t]};
      regs[1] = $urandom;
      regs[1][3:0] = ctab[t];
      for (int i = 2; i < 5; i++) regs[i] = $urandom;
      for (int i = 0; i < 5; i++) host.access(1'b0, amap[i], regs[i]);
      host.idle_bus();
      repeat (250) @(posedge core_clk_i);
      cnt = '{default: 0};
      repeat (240) begin
        @(posedge core_clk_i);
        for (int k = 0; k < 8; k++) cnt[k] += port_oe[k];
        cnt[8] += xo_oe;
      end
      for (int k = 0; k < 9; k++) begin
        c = (k == 8) ? regs[0][3:0] : regs[k / 2 + 1][4 * (k % 2) +: 4];
        x = (c == 4'hf) ? 240 : (c + 1) * mtab[t];
        `CHK("duty", x, cnt[k])
      end
      `CHK("osc", mtab[t] != 4'h0, osc)
      `CHK("oe known", 1'b0, $isunknown({port_oe, xo_oe}))
    end
    repeat (3) @(posedge core_clk_i);
    `CHK("notes left", 0, exp_q.size())
    end_sim();
  end
endmodule
bind lip_intensity_regs lip_intensity_regs_chk u_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .host_req_i(host_req_i), .host_rw_i(host_rw_i),
  .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
  .host_rvalid_o(host_rvalid_o), .host_ack_o(host_ack_o), .host_miss_o(host_miss_o),
  .osc_run_o(osc_run_o), .port_out_o(port_out_o), .port_oe_o(port_oe_o),
  .extra_output_o(extra_output_o), .extra_output_oe_o(extra_output_oe_o));
`default_nettype wire
